/* rtl/ick_pkg.sv */
package ick_pkg;

  localparam int unsigned SIF_ADDR_W    = 7;
  localparam int unsigned REG_W         = 16;
  localparam int unsigned SIF_INSTR_LEN = 8;
  localparam int unsigned SIF_FRAME_LEN = 24;
  localparam int unsigned SIF_CNT_W     = 5;

  localparam logic [6:0]  CTRL_ADDR     = 7'h01;
  localparam logic [6:0]  SERIAL_ADDR   = 7'h02;

  localparam logic [15:0] CTRL_RESET    = 16'h040E;
  localparam logic [15:0] CTRL_WR_MASK  = 16'h9FFE;
  localparam logic        SERIAL_RESET  = 1'b0;

  localparam int unsigned PATTERN_TEST_BIT = 15;
  localparam int unsigned AUTO_CLEAR_BIT   = 12;
  localparam int unsigned PARITY_ODD_BIT   = 11;
  localparam int unsigned SINGLE_PAR_BIT   = 10;
  localparam int unsigned DUAL_PAR_BIT     = 9;
  localparam int unsigned REVERSE_BIT      = 8;
  localparam int unsigned CHAN_A_INV_BIT   = 7;
  localparam int unsigned CHAN_D_INV_BIT   = 4;
  localparam int unsigned TWO_APART_BIT    = 3;
  localparam int unsigned ONE_APART_BIT    = 2;
  localparam int unsigned COLLISION_BIT    = 1;
  localparam int unsigned FOUR_WIRE_BIT    = 7;

  localparam int unsigned ALARM_W          = 6;
  localparam int unsigned AL_COLLISION     = 0;
  localparam int unsigned AL_ONE_APART     = 1;
  localparam int unsigned AL_TWO_APART     = 2;
  localparam int unsigned AL_SINGLE_PAR    = 3;
  localparam int unsigned AL_DUAL_PAR      = 4;
  localparam int unsigned AL_PATTERN       = 5;

  localparam int unsigned GOOD_SAMPLES     = 64;
  localparam int unsigned GOOD_CNT_W       = 6;

endpackage

/* rtl/ick_reg_if.sv */
`timescale 1ns/1ns
interface ick_reg_if;
  logic                              wr_stb;
  logic [ick_pkg::SIF_ADDR_W-1:0]    addr;
  logic [ick_pkg::REG_W-1:0]         wdata;
  logic [ick_pkg::REG_W-1:0]         rdata;
  logic                              four_wire;

  modport serial (
    output wr_stb,
    output addr,
    output wdata,
    input  rdata,
    input  four_wire
  );

  modport regs (
    input  wr_stb,
    input  addr,
    input  wdata,
    output rdata,
    output four_wire
  );
endinterface

/* rtl/ick_parity_chk.sv */
`timescale 1ns/1ns
module ick_parity_chk #(
  parameter int unsigned WIDTH = 64
) (
  input  wire logic [WIDTH-1:0] word,
  input  wire logic             par_bit,
  input  wire logic             odd_sense,
  output logic                  error
);
  // Even sense: word plus bit hold an even count of ones
  assign error = (^{word, par_bit}) != odd_sense;
endmodule

/* rtl/ick_sif_slave.sv */
`timescale 1ns/1ns
module ick_sif_slave (
  input  wire logic  core_clk,
  input  wire logic  rst_b,
  input  wire logic  sif_clk,
  input  wire logic  sif_enable_b,
  input  wire logic  sif_dio_in,
  output logic       sif_dio_out,
  output logic       sif_dio_oe,
  output logic       sif_do_out,
  output logic       sif_do_oe,
  ick_reg_if.serial  rb
);
  logic [2:0]                        clk_sync_q;
  logic [1:0]                        en_sync_q;
  logic [1:0]                        din_sync_q;
  logic [ick_pkg::SIF_CNT_W-1:0]     cnt_q;
  logic [7:0]                        instr_q;
  logic [ick_pkg::REG_W-1:0]         wsh_q;
  logic [ick_pkg::REG_W-1:0]         rsh_q;
  logic                              bit_q;
  logic                              oe_q;
  logic                              active;
  logic                              rise;
  logic                              fall;
  logic                              is_read;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      clk_sync_q <= 3'h0;
      en_sync_q  <= 2'h3;
      din_sync_q <= 2'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], sif_clk};
      en_sync_q  <= {en_sync_q[0], sif_enable_b};
      din_sync_q <= {din_sync_q[0], sif_dio_in};
    end
  end

  assign active  = !en_sync_q[1];
  assign rise    = clk_sync_q[1] && !clk_sync_q[2];
  assign fall    = !clk_sync_q[1] && clk_sync_q[2];
  assign is_read = instr_q[7];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q     <= '0;
      instr_q   <= 8'h00;
      wsh_q     <= 16'h0000;
      rb.wr_stb <= 1'b0;
      rb.wdata  <= 16'h0000;
    end else begin
      rb.wr_stb <= 1'b0;
      if (!active) begin
        cnt_q <= '0;
      end else if (rise && cnt_q < ick_pkg::SIF_FRAME_LEN[4:0]) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q < ick_pkg::SIF_INSTR_LEN[4:0]) begin
          instr_q <= {instr_q[6:0], din_sync_q[1]};
        end else begin
          wsh_q <= {wsh_q[14:0], din_sync_q[1]};
          if (cnt_q == ick_pkg::SIF_FRAME_LEN[4:0] - 5'h01 && !is_read) begin
            rb.wr_stb <= 1'b1;
            rb.wdata  <= {wsh_q[14:0], din_sync_q[1]};
          end
        end
      end
    end
  end

  assign rb.addr = instr_q[6:0];

  // Read data launched on falling edges so the master samples it on rising ones
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rsh_q <= 16'h0000;
      bit_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (!active) begin
      oe_q <= 1'b0;
    end else if (fall && is_read) begin
      if (cnt_q == ick_pkg::SIF_INSTR_LEN[4:0]) begin
        bit_q <= rb.rdata[15];
        rsh_q <= {rb.rdata[14:0], 1'b0};
        oe_q  <= 1'b1;
      end else if (cnt_q < ick_pkg::SIF_FRAME_LEN[4:0]) begin
        bit_q <= rsh_q[15];
        rsh_q <= {rsh_q[14:0], 1'b0};
      end else begin
        oe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sif_dio_out <= 1'b0;
      sif_dio_oe  <= 1'b0;
      sif_do_out  <= 1'b0;
      sif_do_oe   <= 1'b0;
    end else begin
      sif_dio_out <= bit_q;
      sif_do_out  <= bit_q;
      sif_dio_oe  <= oe_q && active && !rb.four_wire;
      sif_do_oe   <= oe_q && active && rb.four_wire;
    end
  end
endmodule

/* rtl/ick_input_check.sv */
`timescale 1ns/1ns
//Contract
// - Pattern test bit on runs the pattern checker and holds outputs off, whatever enables say.
// - Auto-clear bit on clears the alarms after 64 consecutive good samples.
// - Parity sense bit picks even parity at 0 and odd at 1; the source must match it.
// - Single-parity on checks each word against the parity input pair; on after reset.
// - Dual-parity on takes the parity bit from the sample-start strobe pair instead.
// - Reversal bit rotates roles: sync acts as strobe, parity as sync, strobe as parity.
// - Each channel invert bit, A to D, complements that channel's output data.
// - The two-apart pointer alarm is raised only while its enable is on; on after reset.
// - The one-apart pointer alarm is raised only while its enable is on; on after reset.
// - The collision alarm is raised only while its enable is on; on after reset.
// - Serial width bit set makes the serial port four-wire, else three-wire.
module ick_input_check #(
  parameter int unsigned CHAN_W = 16
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  sif_clk,
  input  wire logic                  sif_enable_b,
  input  wire logic                  sif_dio_in,
  output logic                       sif_dio_out,
  output logic                       sif_dio_oe,
  output logic                       sif_do_out,
  output logic                       sif_do_oe,
  input  wire logic                  transmit_enable_pin,
  input  wire logic                  sif_tx_enable,
  input  wire logic                  in_valid,
  input  wire logic [4*CHAN_W-1:0]   in_data,
  input  wire logic                  sync_input_pair,
  input  wire logic                  parity_input_pair,
  input  wire logic                  sample_start_strobe_pair,
  input  wire logic                  fifo_two_apart,
  input  wire logic                  fifo_one_apart,
  input  wire logic                  fifo_collision,
  input  wire logic                  pattern_error,
  input  wire logic                  alarm_clear,
  output logic [4*CHAN_W-1:0]        dac_data,
  output logic                       dac_valid,
  output logic                       sync_role,
  output logic                       strobe_role,
  output logic                       outputs_active,
  output logic                       pattern_check_on,
  output logic [ick_pkg::ALARM_W-1:0] alarm_flags
);
  localparam int unsigned DATA_W = 4 * CHAN_W;

  ick_reg_if rb ();

  logic [15:0]                        ctrl_q;
  logic                               four_wire_q;
  logic [1:0]                         valid_sync_q;
  logic [DATA_W-1:0]                  data_sync0_q;
  logic [DATA_W-1:0]                  data_sync1_q;
  logic [1:0]                         sync_sync_q;
  logic [1:0]                         par_sync_q;
  logic [1:0]                         strb_sync_q;
  logic [1:0]                         txen_sync_q;
  logic                               sync_sel;
  logic                               par_sel;
  logic                               strb_sel;
  logic                               single_err_raw;
  logic                               dual_err_raw;
  logic                               single_err;
  logic                               dual_err;
  logic                               good_sample;
  logic                               bad_sample;
  logic [ick_pkg::GOOD_CNT_W-1:0]     good_cnt_q;
  logic                               auto_clear;
  logic [ick_pkg::ALARM_W-1:0]        alarm_set;
  logic                               tx_allowed;
  logic [DATA_W-1:0]                  inv_mask;

  ick_sif_slave u_sif (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .sif_clk      (sif_clk),
    .sif_enable_b (sif_enable_b),
    .sif_dio_in   (sif_dio_in),
    .sif_dio_out  (sif_dio_out),
    .sif_dio_oe   (sif_dio_oe),
    .sif_do_out   (sif_do_out),
    .sif_do_oe    (sif_do_oe),
    .rb           (rb.serial)
  );

  // Register writes; reserved bits are masked so they always hold zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_q <= ick_pkg::CTRL_RESET;
    end else if (rb.wr_stb && rb.addr == ick_pkg::CTRL_ADDR) begin
      ctrl_q <= rb.wdata & ick_pkg::CTRL_WR_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      four_wire_q <= ick_pkg::SERIAL_RESET;
    end else if (rb.wr_stb && rb.addr == ick_pkg::SERIAL_ADDR) begin
      four_wire_q <= rb.wdata[ick_pkg::FOUR_WIRE_BIT];
    end
  end

  assign rb.four_wire = four_wire_q;

  // Other fields of the serial width register belong elsewhere and read zero here
  always_comb begin
    rb.rdata = 16'h0000;
    case (rb.addr)
      ick_pkg::CTRL_ADDR:   rb.rdata = ctrl_q;
      ick_pkg::SERIAL_ADDR: rb.rdata[ick_pkg::FOUR_WIRE_BIT] = four_wire_q;
      default:              rb.rdata = 16'h0000;
    endcase
  end

  // Pin inputs pass two flops before any logic
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      valid_sync_q <= 2'h0;
      data_sync0_q <= '0;
      data_sync1_q <= '0;
      sync_sync_q  <= 2'h0;
      par_sync_q   <= 2'h0;
      strb_sync_q  <= 2'h0;
      txen_sync_q  <= 2'h0;
    end else begin
      valid_sync_q <= {valid_sync_q[0], in_valid};
      data_sync0_q <= in_data;
      data_sync1_q <= data_sync0_q;
      sync_sync_q  <= {sync_sync_q[0], sync_input_pair};
      par_sync_q   <= {par_sync_q[0], parity_input_pair};
      strb_sync_q  <= {strb_sync_q[0], sample_start_strobe_pair};
      txen_sync_q  <= {txen_sync_q[0], transmit_enable_pin};
    end
  end

  // Role rotation lets a board lay the bus out mirrored
  always_comb begin
    if (ctrl_q[ick_pkg::REVERSE_BIT]) begin
      strb_sel = sync_sync_q[1];
      sync_sel = par_sync_q[1];
      par_sel  = strb_sync_q[1];
    end else begin
      strb_sel = strb_sync_q[1];
      sync_sel = sync_sync_q[1];
      par_sel  = par_sync_q[1];
    end
  end

  ick_parity_chk #(
    .WIDTH (DATA_W)
  ) u_single_par (
    .word      (data_sync1_q),
    .par_bit   (par_sel),
    .odd_sense (ctrl_q[ick_pkg::PARITY_ODD_BIT]),
    .error     (single_err_raw)
  );

  ick_parity_chk #(
    .WIDTH (DATA_W)
  ) u_dual_par (
    .word      (data_sync1_q),
    .par_bit   (strb_sel),
    .odd_sense (ctrl_q[ick_pkg::PARITY_ODD_BIT]),
    .error     (dual_err_raw)
  );

  assign single_err = valid_sync_q[1] && ctrl_q[ick_pkg::SINGLE_PAR_BIT] && single_err_raw;
  assign dual_err   = valid_sync_q[1] && ctrl_q[ick_pkg::DUAL_PAR_BIT] && dual_err_raw;

  assign bad_sample  = single_err || dual_err || pattern_error;
  assign good_sample = valid_sync_q[1] && !bad_sample;

  // A parity or pattern error restarts the run, so only consecutive good samples count
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      good_cnt_q <= '0;
    end else if (!ctrl_q[ick_pkg::AUTO_CLEAR_BIT] || bad_sample) begin
      good_cnt_q <= '0;
    end else if (good_sample) begin
      good_cnt_q <= good_cnt_q + 6'h01;
    end
  end

  assign auto_clear = ctrl_q[ick_pkg::AUTO_CLEAR_BIT] && good_sample &&
                      good_cnt_q == 6'(ick_pkg::GOOD_SAMPLES - 1);

  always_comb begin
    alarm_set = '0;
    alarm_set[ick_pkg::AL_TWO_APART]  = fifo_two_apart && ctrl_q[ick_pkg::TWO_APART_BIT];
    alarm_set[ick_pkg::AL_ONE_APART]  = fifo_one_apart && ctrl_q[ick_pkg::ONE_APART_BIT];
    alarm_set[ick_pkg::AL_COLLISION]  = fifo_collision && ctrl_q[ick_pkg::COLLISION_BIT];
    alarm_set[ick_pkg::AL_SINGLE_PAR] = single_err;
    alarm_set[ick_pkg::AL_DUAL_PAR]   = dual_err;
    alarm_set[ick_pkg::AL_PATTERN]    = pattern_error && ctrl_q[ick_pkg::PATTERN_TEST_BIT];
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      alarm_flags <= '0;
    end else if (alarm_clear || auto_clear) begin
      alarm_flags <= alarm_set;
    end else begin
      alarm_flags <= alarm_flags | alarm_set;
    end
  end

  assign tx_allowed = txen_sync_q[1] && sif_tx_enable && !ctrl_q[ick_pkg::PATTERN_TEST_BIT];

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_inv
      assign inv_mask[DATA_W-1-ch*CHAN_W -: CHAN_W] =
        {CHAN_W{ctrl_q[ick_pkg::CHAN_A_INV_BIT-ch]}};
    end
  endgenerate

  // Channel A sits in the top lane of the bus, D in the bottom
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dac_data  <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_data  <= tx_allowed ? (data_sync1_q ^ inv_mask) : '0;
      dac_valid <= tx_allowed && valid_sync_q[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync_role        <= 1'b0;
      strobe_role      <= 1'b0;
      outputs_active   <= 1'b0;
      pattern_check_on <= 1'b0;
    end else begin
      sync_role        <= sync_sel;
      strobe_role      <= strb_sel;
      outputs_active   <= tx_allowed;
      pattern_check_on <= ctrl_q[ick_pkg::PATTERN_TEST_BIT];
    end
  end

endmodule

/* verification/ick_input_check_checker.sv */
`timescale 1ns/1ns
module ick_input_check_checker #(
  parameter int unsigned CHAN_W = 16
) (
  input wire logic                         core_clk,
  input wire logic                         rst_b,
  input wire logic                         sif_enable_b,
  input wire logic                         sif_dio_oe,
  input wire logic                         sif_do_oe,
  input wire logic                         sync_input_pair,
  input wire logic                         parity_input_pair,
  input wire logic                         fifo_two_apart,
  input wire logic                         fifo_one_apart,
  input wire logic                         fifo_collision,
  input wire logic                         pattern_error,
  input wire logic [4*CHAN_W-1:0]          dac_data,
  input wire logic                         dac_valid,
  input wire logic                         sync_role,
  input wire logic                         outputs_active,
  input wire logic                         pattern_check_on,
  input wire logic [ick_pkg::ALARM_W-1:0]  alarm_flags
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_sif_idle;
    sif_enable_b [*6];
  endsequence
  sequence s_off;
    !outputs_active [*2];
  endsequence
  // Reset itself is the cause here, so it must not disable the check
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> alarm_flags == '0
    && !sif_dio_oe && !sif_do_oe && !outputs_active) else $error("outputs live after reset");
  a_oe_exclusive: assert property (!(sif_dio_oe && sif_do_oe))
    else $error("both serial outputs driven");
  a_oe_idle: assert property (s_sif_idle |-> !sif_dio_oe && !sif_do_oe)
    else $error("serial output driven outside frame");
  a_dac_off: assert property (s_off |-> dac_data == '0 && !dac_valid)
    else $error("data passes while outputs off");
  a_pattern_gates: assert property (pattern_check_on [*2] |-> !outputs_active)
    else $error("outputs active in pattern test");
  a_coll_cause: assert property ($rose(alarm_flags[ick_pkg::AL_COLLISION])
    |-> $past(fifo_collision)) else $error("collision alarm without event");
  a_one_cause: assert property ($rose(alarm_flags[ick_pkg::AL_ONE_APART])
    |-> $past(fifo_one_apart)) else $error("one-apart alarm without event");
  a_two_cause: assert property ($rose(alarm_flags[ick_pkg::AL_TWO_APART])
    |-> $past(fifo_two_apart)) else $error("two-apart alarm without event");
  a_pattern_cause: assert property ($rose(alarm_flags[ick_pkg::AL_PATTERN])
    |-> $past(pattern_error) && ($past(pattern_check_on) || pattern_check_on))
    else $error("pattern alarm without error");
  a_sync_rotates: assert property (rst_b && $past(rst_b, 4) |->
    sync_role == $past(sync_input_pair, 3) || sync_role == $past(parity_input_pair, 3))
    else $error("sync role from wrong pin");
endmodule

bind ick_input_check ick_input_check_checker #(.CHAN_W(CHAN_W)) i_ick_input_check_checker (
  .core_clk, .rst_b, .sif_enable_b, .sif_dio_oe, .sif_do_oe, .sync_input_pair,
  .parity_input_pair, .fifo_two_apart, .fifo_one_apart, .fifo_collision, .pattern_error,
  .dac_data, .dac_valid, .sync_role, .outputs_active, .pattern_check_on, .alarm_flags
);

/* verification/ick_src_model.sv */
`timescale 1ns/1ns
module ick_src_model (
  input  wire logic [63:0] data,
  input  wire logic        valid_on,
  input  wire logic        odd_sense,
  input  wire logic        corrupt,
  input  wire logic        reversed,
  input  wire logic        sync_lvl,
  output logic             in_valid,
  output logic [63:0]      in_data,
  output logic             sync_input_pair,
  output logic             parity_input_pair,
  output logic             sample_start_strobe_pair
);
  logic par;
  // Corrupt only on command, so a clean source never trips the check
  assign par = ^data ^ odd_sense ^ corrupt;
  assign in_valid = valid_on;
  assign in_data = data;
  // Strobe also carries parity so dual checking sees a real bit
  assign sample_start_strobe_pair = par;
  assign sync_input_pair = reversed ? par : sync_lvl;
  assign parity_input_pair = reversed ? sync_lvl : par;
endmodule

/* verification/test_input_check_config_register.sv */
`timescale 1ns/1ns
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("ERROR %0t %s", $time, m); end end
module test_input_check_config_register;
  logic core_clk, rst_b, sif_clk, sif_enable_b, tb_dio, tx_pin, tx_sw, f2, f1, fc, pat_err;
  logic al_clr, dio_out, dio_oe, do_out, do_oe, in_valid, sync_p, par_p, stb_p, src_valid;
  logic odd, bad, rev, sync_lvl, dac_valid, sync_role, strobe_role, out_act, pat_on, four_q;
  logic [63:0] in_data, src_data, dac_data;
  logic [5:0]  alarms;
  wire         sif_dio;
  int          failures, samples_checked;
  assign sif_dio = dio_oe ? dio_out : tb_dio;
  ick_input_check i_ick_input_check (.core_clk(core_clk), .rst_b(rst_b), .sif_clk(sif_clk),
    .sif_enable_b(sif_enable_b), .sif_dio_in(sif_dio), .sif_dio_out(dio_out),
    .sif_dio_oe(dio_oe), .sif_do_out(do_out), .sif_do_oe(do_oe), .transmit_enable_pin(tx_pin),
    .sif_tx_enable(tx_sw), .in_valid(in_valid), .in_data(in_data), .sync_input_pair(sync_p),
    .parity_input_pair(par_p), .sample_start_strobe_pair(stb_p), .fifo_two_apart(f2),
    .fifo_one_apart(f1), .fifo_collision(fc), .pattern_error(pat_err), .alarm_clear(al_clr),
    .dac_data(dac_data), .dac_valid(dac_valid), .sync_role(sync_role),
    .strobe_role(strobe_role), .outputs_active(out_act), .pattern_check_on(pat_on),
    .alarm_flags(alarms));
  ick_src_model i_ick_src_model (.data(src_data), .valid_on(src_valid), .odd_sense(odd),
    .corrupt(bad), .reversed(rev), .sync_lvl(sync_lvl), .in_valid(in_valid),
    .in_data(in_data), .sync_input_pair(sync_p), .parity_input_pair(par_p),
    .sample_start_strobe_pair(stb_p));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Half period of 8 cycles leaves room for the two sync flops
  task automatic sif_xfer(input logic [7:0] ins, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] fr;
    // Reads send ones so an undriven pin cannot pass for zero data
    fr = {ins, ins[7] ? 16'hFFFF : wd};
    rd = '0;
    tick(1);
    sif_enable_b <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      tb_dio <= fr[i];
      tick(8);
      if (i < 16) begin
        rd[i] = four_q ? (do_oe ? do_out : 1'b1) : sif_dio;
        if (ins[7] && ins[6:0] inside {7'h01, 7'h02}) begin
          `CHK({dio_oe, do_oe}, four_q ? 2'b01 : 2'b10, "read pin choice")
        end
      end
      sif_clk <= 1'b1;
      tick(8);
      sif_clk <= 1'b0;
    end
    tick(8);
    sif_enable_b <= 1'b1;
    tick(8);
  endtask
  task automatic clear();
    al_clr <= 1'b1;
    tick(1);
    al_clr <= 1'b0;
    tick(2);
    `CHK(alarms, 6'h00, "alarms not cleared")
  endtask
  task automatic t_regs();
    logic [15:0] r;
    sif_xfer(8'h81, 16'h0000, r);
    `CHK(r, 16'h040E, "ctrl default")
    sif_xfer(8'h82, 16'h0000, r);
    `CHK(r, 16'h0000, "width default")
    sif_xfer(8'h01, 16'hFFFF, r);
    sif_xfer(8'h81, 16'h0000, r);
    `CHK(r, 16'h9FFE, "reserved bits")
    sif_xfer(8'h05, 16'hFFFF, r);
    sif_xfer(8'h85, 16'h0000, r);
    `CHK(r, 16'h0000, "unmapped read")
    sif_xfer(8'h01, 16'h040E, r);
    clear();
  endtask
  task automatic t_invert();
    logic [15:0] r;
    logic [63:0] m;
    src_valid <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      m = (k == 4) ? 64'h0 : 64'hFFFF << (16 * (3 - k));
      sif_xfer(8'h01, 16'h040E | (16'h0080 >> k), r);
      `CHK(dac_data, 64'h0123456789ABCDEF ^ m, "channel invert")
      `CHK(dac_valid, 1'b1, "valid lost")
    end
  endtask
  task automatic t_pattern();
    logic [15:0] r;
    sif_xfer(8'h01, 16'h840E, r);
    `CHK({pat_on, out_act, dac_valid}, 3'b100, "pattern test gating")
    pat_err <= 1'b1;
    tick(1);
    pat_err <= 1'b0;
    tick(2);
    `CHK(alarms[ick_pkg::AL_PATTERN], 1'b1, "pattern alarm")
    sif_xfer(8'h01, 16'h040E, r);
    `CHK({pat_on, out_act}, 2'b01, "outputs back")
    tx_pin <= 1'b0;
    tick(6);
    `CHK({out_act, dac_valid}, 2'b00, "pin gating")
    tx_pin <= 1'b1;
    tx_sw <= 1'b0;
    tick(6);
    `CHK({out_act, dac_valid}, 2'b00, "software gating")
    tx_sw <= 1'b1;
    tick(6);
    `CHK({out_act, dac_valid}, 2'b11, "gating released")
    clear();
  endtask
  task automatic t_parity();
    logic [15:0] r;
    logic [15:0] cfg [4] = '{16'h040E, 16'h0C0E, 16'h020E, 16'h050E};
    int bitn [4] = '{3, 3, 4, 3};
    for (int i = 0; i < 4; i++) begin
      odd <= cfg[i][11];
      rev <= cfg[i][8];
      sync_lvl <= ~cfg[i][11];
      sif_xfer(8'h01, cfg[i], r);
      clear();
      tick(8);
      `CHK(alarms[bitn[i]], 1'b0, "good parity flagged")
      `CHK({sync_role, strobe_role}, {~cfg[i][11], cfg[i][11]}, "sideband roles")
      bad <= 1'b1;
      tick(8);
      `CHK(alarms[bitn[i]], 1'b1, "bad parity missed")
      bad <= 1'b0;
    end
    odd <= 1'b0;
    rev <= 1'b0;
    sif_xfer(8'h01, 16'h040E, r);
    clear();
  endtask
  task automatic t_fifo();
    logic [15:0] r;
    for (int k = 0; k < 4; k++) begin
      sif_xfer(8'h01, 16'h0400 | ((k < 3) ? 16'h0002 << k : 16'h0000), r);
      clear();
      {f2, f1, fc} <= 3'b111;
      tick(1);
      {f2, f1, fc} <= 3'b000;
      tick(2);
      `CHK(alarms[2:0], (k < 3) ? 3'b001 << k : 3'b000, "fifo alarm enables")
    end
  endtask
  task automatic t_auto();
    logic [15:0] r;
    src_valid <= 1'b0;
    sif_xfer(8'h01, 16'h140E, r);
    fc <= 1'b1;
    tick(1);
    fc <= 1'b0;
    src_valid <= 1'b1;
    tick(63);
    src_valid <= 1'b0;
    tick(6);
    `CHK(alarms[0], 1'b1, "cleared before 64")
    src_valid <= 1'b1;
    tick(1);
    src_valid <= 1'b0;
    tick(6);
    `CHK(alarms[0], 1'b0, "kept after 64")
  endtask
  task automatic t_four();
    logic [15:0] r;
    sif_xfer(8'h02, 16'h0080, r);
    four_q = 1'b1;
    sif_xfer(8'h81, 16'h0000, r);
    `CHK(r, 16'h140E, "four-wire read")
    sif_xfer(8'h02, 16'h0000, r);
    four_q = 1'b0;
    sif_xfer(8'h82, 16'h0000, r);
    `CHK(r, 16'h0000, "three-wire read")
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  initial begin
    {sif_clk, tb_dio, f2, f1, fc, pat_err, al_clr, src_valid, odd, bad, rev, four_q} = '0;
    {sif_enable_b, tx_pin, tx_sw, sync_lvl} = 4'hF;
    src_data = 64'h0123456789ABCDEF;
    rst_b = 1'b0;
    tick(4);
    rst_b <= 1'b1;
    tick(3);
    t_regs();
    t_invert();
    t_pattern();
    t_parity();
    t_fifo();
    t_auto();
    t_four();
    give_verdict();
  end
endmodule
